// File: dv/host_model.sv
// Purpose: host side of the byte register port
// Assumes: strobes last one edge, data taken at the next falling edge
// Notes: reserved config bits are always sent as zero
`timescale 1ns/1ps
`include "persist_filter_regs.vh"
module host_model (
  // clock and read data
  input wire i_clk,
  input wire [7:0] i_rdata,
  // strobes, address, data
  output reg o_wr,
  output reg o_rd,
  output reg [7:0] o_addr,
  output reg [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= (a == `CONFIG_ZERO_ADDR) ? (d & `CONFIG_ZERO_USED_MASK) : d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// File: dv/persist_filter_props.sv
// Purpose: port-level checks of persist_filter
// Assumes: single clock domain
// Notes: internal reset lags I_NRST by two edges
`timescale 1ns/1ps
`include "persist_filter_regs.vh"
module persist_filter_props (
  // clock and reset
  input wire I_SYS_CLK,
  input wire I_NRST,
  // inputs watched
  input wire I_REG_RD,
  input wire [7:0] I_REG_ADDR,
  input wire I_PROX_DONE,
  input wire I_LIGHT_DONE,
  input wire I_LIGHT_IRQ_ENABLE,
  input wire I_FUNCS_IDLE,
  input wire I_WAIT_START,
  // outputs watched
  input wire [7:0] O_REG_RDATA,
  input wire O_PROX_IRQ,
  input wire O_LIGHT_IRQ,
  input wire O_WAIT_ACTIVE,
  input wire O_LOW_POWER
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);
  property p_unmap; I_REG_RD && I_REG_ADDR > `CONFIG_ZERO_ADDR |=> O_REG_RDATA == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold; !I_REG_RD |=> $stable(O_REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_pdone; O_PROX_IRQ |-> $past(I_PROX_DONE); endproperty
  a_pdone: assert property (p_pdone) else $error("stray prox irq");
  property p_ldone; O_LIGHT_IRQ |-> $past(I_LIGHT_DONE); endproperty
  a_ldone: assert property (p_ldone) else $error("stray light irq");
  property p_len; O_LIGHT_IRQ |-> $past(I_LIGHT_IRQ_ENABLE); endproperty
  a_len: assert property (p_len) else $error("light irq disabled");
  property p_wrise; $rose(O_WAIT_ACTIVE) |-> $past(I_WAIT_START); endproperty
  a_wrise: assert property (p_wrise) else $error("wait unasked");
  property p_wgo; I_WAIT_START && !O_WAIT_ACTIVE |=> O_WAIT_ACTIVE; endproperty
  a_wgo: assert property (p_wgo) else $error("wait not begun");
  property p_lp; O_LOW_POWER |-> $past(I_FUNCS_IDLE); endproperty
  a_lp: assert property (p_lp) else $error("low power while busy");
endmodule
bind persist_filter persist_filter_props props (.*);

// File: dv/tb_top.sv
// Purpose: self-checking bench for persist_filter
// Assumes: wait step shortened to 4 cycles
// Notes: samples are 2 cycles apart, so pulses never merge
`timescale 1ns/1ps
`include "persist_filter_regs.vh"
module tb_top;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg pd = 1'b0, ld = 1'b0, idle = 1'b0, ws = 1'b0, len = 1'b1;
  reg [15:0] res = 16'h0000;
  wire wr, rd, pirq, lirq, wact, lp;
  wire [7:0] addr, wdat, rdat;
  integer mismatches = 0, n_tests = 0, k, c;
  reg [7:0] v;
  reg o;
  always #5 clk = ~clk;
  host_model host (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdat));
  persist_filter #(.WAIT_STEP_CYCLES(4)) dut (.I_SYS_CLK(clk),
    .I_NRST(nrst), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdat), .O_REG_RDATA(rdat), .I_PROX_LOW_THRESHOLD(16'd100),
    .I_PROX_HIGH_THRESHOLD(16'd200), .I_LIGHT_LOW_THRESHOLD(16'd100),
    .I_LIGHT_HIGH_THRESHOLD(16'd200), .I_LIGHT_IRQ_ENABLE(len),
    .I_PROX_IRQ_ENABLE(1'b1), .I_WAIT_PERIOD_SETTING(8'hFE),
    .I_PROX_DONE(pd), .I_PROX_RESULT(res), .I_LIGHT_DONE(ld),
    .I_CLEAR_CHANNEL_RESULT(res), .I_FUNCS_IDLE(idle), .I_WAIT_START(ws),
    .O_PROX_IRQ(pirq), .O_LIGHT_IRQ(lirq), .O_WAIT_ACTIVE(wact),
    .O_LOW_POWER(lp));
  task chk(input string nm, input [7:0] s, input [7:0] e);
    n_tests = n_tests + 1;
    if (s !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0s expected %h seen %h", nm, e, s);
    end
  endtask
  // one completed sample; the pulse is read after the taking edge settles
  task samp(input p, input [15:0] r);
    @(posedge clk);
    pd <= p;
    ld <= !p;
    res <= r;
    @(posedge clk);
    pd <= 1'b0;
    ld <= 1'b0;
    @(negedge clk);
    o = p ? pirq : lirq;
  endtask
  task t_regs;
    host.rd(`INTERRUPT_PERSISTENCE_ADDR, v);
    chk("interrupt_persistence_reset", v, `INTERRUPT_PERSISTENCE_RESET);
    host.rd(`CONFIG_ZERO_ADDR, v);
    chk("config_zero_reset", v, `CONFIG_ZERO_RESET);
    host.wr(`INTERRUPT_PERSISTENCE_ADDR, 8'hA5);
    host.rd(`INTERRUPT_PERSISTENCE_ADDR, v);
    chk("interrupt_persistence_rw", v, 8'hA5);
    host.rd(8'h8E, v);
    chk("unmapped", v, 8'h00);
    $display("regs done");
  endtask
  task t_prox;
    host.wr(`INTERRUPT_PERSISTENCE_ADDR, 8'h20);
    for (k = 0; k < 5; k = k + 1) begin
      samp(1'b1, k == 1 ? 16'd150 : k == 4 ? 16'd50 : 16'd300);
      chk("prox_irq", o, k > 2);
    end
    host.wr(`INTERRUPT_PERSISTENCE_ADDR, 8'h00);
    samp(1'b1, 16'd150);
    chk("prox_zero", o, 1);
    $display("prox done");
  endtask
  // in-range sample first, so the saturated count must be cleared
  task t_light;
    for (k = 0; k < 16; k = k + 1) begin
      host.wr(`INTERRUPT_PERSISTENCE_ADDR, k[7:0]);
      samp(1'b0, 16'd150);
      c = 0;
      o = 0;
      while (o !== 1'b1 && c < 70) begin
        samp(1'b0, 16'd300);
        c = c + 1;
      end
      chk("light_count", c, k == 0 ? 1 : k < 4 ? k : 5 * (k - 3));
    end
    len <= 1'b0;
    samp(1'b0, 16'd300);
    chk("light_masked", o, 0);
    len <= 1'b1;
    $display("light done");
  endtask
  task t_wait;
    for (k = 0; k < 2; k = k + 1) begin
      host.wr(`CONFIG_ZERO_ADDR, k ? 8'h04 : 8'h00);
      @(posedge clk);
      ws <= 1'b1;
      @(posedge clk);
      ws <= 1'b0;
      @(negedge clk);
      c = 0;
      while (wact === 1'b1 && c < 200) begin
        @(negedge clk);
        c = c + 1;
      end
      chk("wait_len", c, (k ? 12 : 1) * 2 * 4);
    end
    $display("wait done");
  endtask
  task t_lp;
    host.wr(`CONFIG_ZERO_ADDR, 8'h20);
    repeat (2) @(negedge clk);
    chk("lp_busy", lp, 0);
    idle <= 1'b1;
    repeat (3) @(negedge clk);
    chk("lp_idle", lp, 1);
    host.wr(`CONFIG_ZERO_ADDR, 8'h00);
    repeat (3) @(negedge clk);
    chk("lp_off", lp, 0);
    $display("low power done");
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // generous: the light sweep is near 860 cycles
  initial begin
    #200000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_prox;
    t_light;
    t_wait;
    t_lp;
    wrap_up;
  end
endmodule

// File: hw/persist_filter.v
// Purpose: persistence filtering of proximity and light threshold events,
//   low-power idle and wait period stretch control
// Assumes: sample strobes and results arrive synchronous to I_SYS_CLK
// Notes: registers written through a byte-wide internal register port
`timescale 1ns/1ps
`include "persist_filter_regs.vh"

// How it works
// - prox setting in bits 7:4 counts out-of-range
// - in-range prox sample clears prox counter
// - prox setting zero: interrupt every sample
// - prox setting N: interrupt after N samples
// - light setting in bits 3:0 counts out-of-range
// - in-range light sample clears light counter
// - light setting zero: interrupt every sample
// - light settings 1..3 need that many samples
// - light settings 4..15 need 5*(N-3) samples
// - low-power bit idles when all wait/disabled
// - wait-stretch bit makes waits twelve times longer
// - wait is 0.15856ms times (256 - setting): the 278000-cycle 2.78ms step is cut to 18 bits
// - light out of range, gated by enable
// - prox below low or above high qualifies
module persist_filter #(
  parameter WAIT_STEP_CYCLES = `WAIT_STEP_CYCLES
) (
  // clock and reset
  input wire I_SYS_CLK,
  input wire I_NRST,
  // register port
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [7:0] I_REG_ADDR,
  input wire [7:0] I_REG_WDATA,
  output reg [7:0] O_REG_RDATA,
  // thresholds, enables and wait setting from neighbouring registers
  input wire [15:0] I_PROX_LOW_THRESHOLD,
  input wire [15:0] I_PROX_HIGH_THRESHOLD,
  input wire [15:0] I_LIGHT_LOW_THRESHOLD,
  input wire [15:0] I_LIGHT_HIGH_THRESHOLD,
  input wire I_LIGHT_IRQ_ENABLE,
  input wire I_PROX_IRQ_ENABLE,
  input wire [7:0] I_WAIT_PERIOD_SETTING,
  // sample results
  input wire I_PROX_DONE,
  input wire [15:0] I_PROX_RESULT,
  input wire I_LIGHT_DONE,
  input wire [15:0] I_CLEAR_CHANNEL_RESULT,
  // function state for low-power decision, and wait start
  input wire I_FUNCS_IDLE,
  input wire I_WAIT_START,
  // outputs
  output reg O_PROX_IRQ,
  output reg O_LIGHT_IRQ,
  output reg O_WAIT_ACTIVE,
  output reg O_LOW_POWER
);

  ////////////////////////////////////////////////////////////////////////
  // reset synchroniser
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function out_of_range;
    input [15:0] value;
    input [15:0] low;
    input [15:0] high;
    begin
      out_of_range = (value < low) || (value > high);
    end
  endfunction

  // light target: 1..3 as is, above that 5*(N-3), top value 60
  function [5:0] light_target;
    input [3:0] n;
    reg [5:0] m;
    begin
      m = {2'b00, n} - 6'h03;
      if (n < 4'h4)
        light_target = {2'b00, n};
      else
        light_target = {m[3:0], 2'b00} + m;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0] interrupt_persistence_reg;
  reg [7:0] config_zero_reg;
  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_persistence_reg <= `INTERRUPT_PERSISTENCE_RESET;
      config_zero_reg <= `CONFIG_ZERO_RESET;
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == `INTERRUPT_PERSISTENCE_ADDR)
        interrupt_persistence_reg <= I_REG_WDATA;
      if (I_REG_ADDR == `CONFIG_ZERO_ADDR)
        config_zero_reg <= I_REG_WDATA & `CONFIG_ZERO_USED_MASK;
    end
  end

  wire [3:0] prox_persist_count = interrupt_persistence_reg[`PROX_INTERRUPT_PERSISTENCE_HI:`PROX_INTERRUPT_PERSISTENCE_LO];
  wire [3:0] light_persist_count = interrupt_persistence_reg[`LIGHT_INTERRUPT_PERSISTENCE_HI:`LIGHT_INTERRUPT_PERSISTENCE_LO];
  wire low_power_a = config_zero_reg[`LOW_POWER_BIT];
  wire wait_stretch = config_zero_reg[`WAIT_STRETCH_BIT];

  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      O_REG_RDATA <= 8'h00;
    else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `INTERRUPT_PERSISTENCE_ADDR: O_REG_RDATA <= interrupt_persistence_reg;
        `CONFIG_ZERO_ADDR: O_REG_RDATA <= config_zero_reg;
        default: O_REG_RDATA <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // persistence counters; settings sampled live at each done strobe
  reg [3:0] prox_cnt_reg;
  reg [5:0] light_cnt_reg;
  wire prox_oor = out_of_range(I_PROX_RESULT, I_PROX_LOW_THRESHOLD,
                               I_PROX_HIGH_THRESHOLD);
  wire light_oor = out_of_range(I_CLEAR_CHANNEL_RESULT,
                                I_LIGHT_LOW_THRESHOLD,
                                I_LIGHT_HIGH_THRESHOLD);
  wire [3:0] prox_cnt_inc = prox_cnt_reg + 4'h1;
  wire [5:0] light_cnt_inc = light_cnt_reg + 6'h01;
  wire [5:0] light_goal = light_target(light_persist_count);

  // counters saturate at the target so a long excursion keeps firing, except prox setting 15, where the 4-bit increment wraps to 0
  wire prox_hit = (prox_persist_count == 4'h0) ||
                  (prox_oor && prox_cnt_inc >= prox_persist_count);
  wire light_hit = (light_persist_count == 4'h0) ||
                   (light_oor && light_cnt_inc >= light_goal);

  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prox_cnt_reg <= 4'h0;
      light_cnt_reg <= 6'h00;
      O_PROX_IRQ <= 1'b0;
      O_LIGHT_IRQ <= 1'b0;
    end else begin
      O_PROX_IRQ <= 1'b0;
      O_LIGHT_IRQ <= 1'b0;
      if (I_PROX_DONE) begin
        if (!prox_oor)
          prox_cnt_reg <= 4'h0;
        else if (prox_cnt_inc < prox_persist_count)
          prox_cnt_reg <= prox_cnt_inc;
        else
          prox_cnt_reg <= prox_persist_count;
        O_PROX_IRQ <= prox_hit && I_PROX_IRQ_ENABLE;
      end
      if (I_LIGHT_DONE) begin
        if (!light_oor)
          light_cnt_reg <= 6'h00;
        else if (light_cnt_inc < light_goal)
          light_cnt_reg <= light_cnt_inc;
        else
          light_cnt_reg <= light_goal;
        O_LIGHT_IRQ <= light_hit && I_LIGHT_IRQ_ENABLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wait timer: steps of WAIT_STEP_CYCLES[17:0] cycles, (256 - setting) steps
  reg [17:0] tick_reg;
  reg [3:0] stretch_reg;
  reg [8:0] steps_reg;
  wire [8:0] wait_steps = 9'h100 - {1'b0, I_WAIT_PERIOD_SETTING};
  wire tick_end = (tick_reg == WAIT_STEP_CYCLES[17:0] - 18'h1);
  wire [3:0] stretch_max = wait_stretch ?
                           4'(`WAIT_STRETCH_FACTOR - 1) : 4'h0;

  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_WAIT_ACTIVE <= 1'b0;
      tick_reg <= 18'h0;
      stretch_reg <= 4'h0;
      steps_reg <= 9'h0;
    end else if (I_WAIT_START && !O_WAIT_ACTIVE) begin
      O_WAIT_ACTIVE <= 1'b1;
      tick_reg <= 18'h0;
      stretch_reg <= 4'h0;
      steps_reg <= wait_steps;
    end else if (O_WAIT_ACTIVE) begin
      tick_reg <= tick_end ? 18'h0 : tick_reg + 18'h1;
      if (tick_end) begin
        if (stretch_reg < stretch_max) begin
          stretch_reg <= stretch_reg + 4'h1;
        end else begin
          stretch_reg <= 4'h0;
          steps_reg <= steps_reg - 9'h1;
          if (steps_reg == 9'h1)
            O_WAIT_ACTIVE <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // low power idle
  always @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n)
      O_LOW_POWER <= 1'b0;
    else
      O_LOW_POWER <= low_power_a && I_FUNCS_IDLE;
  end

endmodule

// File: hw/persist_filter_regs.vh
// Purpose: constants for the interrupt persistence filter block
// Assumes: byte-wide registers on the device's internal register port
// Notes: timing counts are derived at 100 MHz
`ifndef PERSIST_FILTER_REGS_VH
`define PERSIST_FILTER_REGS_VH

`define INTERRUPT_PERSISTENCE_ADDR 8'h8C
`define CONFIG_ZERO_ADDR 8'h8D
`define INTERRUPT_PERSISTENCE_RESET 8'h00
`define CONFIG_ZERO_RESET 8'h00
`define WAIT_SETTING_RESET 8'hFF

`define PROX_INTERRUPT_PERSISTENCE_HI 7
`define PROX_INTERRUPT_PERSISTENCE_LO 4
`define LIGHT_INTERRUPT_PERSISTENCE_HI 3
`define LIGHT_INTERRUPT_PERSISTENCE_LO 0
`define LOW_POWER_BIT 5
`define WAIT_STRETCH_BIT 2
`define CONFIG_ZERO_USED_MASK 8'h24

// base wait step 2.78 ms, expressed in ns, and its cycle count at 10 ns
`define WAIT_STEP_NS 2780000
`define CLK_PERIOD_NS 10
`define WAIT_STEP_CYCLES (`WAIT_STEP_NS / `CLK_PERIOD_NS)
`define WAIT_STRETCH_FACTOR 12

`endif
